// [logic/pmlf_port_mode.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - status_append_disable set: no status word appended
// - clear: status follows last data beat
// - byte_order_select: 1 big endian, 0 little
// - lock_reference_enable: lock output when idle line, pcs mode
// - comma_detect_force: comma enable always on in pcs mode
// - otherwise comma enable only when sync lost
// - loopback: tx to rx, line muted, rejected
// - cpu_width_select: 16-bit or low 8-bit bus
// - detect_override forces signal detect high, pcs
// - pcs mode bit selects phy interface type
module pmlf_port_mode (
  input  wire logic                sys_clk_i,         // device clock, 25 MHz
  input  wire logic                rst_n_i,           // synchronous reset, active low
  input  wire pmlf_pkg::pmlf_cpu_s cpu_req_i,         // cpu port pins, asynchronous
  output logic [15:0]              cpu_rdata_o,       // cpu read data
  output logic                     cpu_rdata_oe_o,    // high while driving cpu data pins
  input  wire logic                line_signal_detect_in_i, // signal detect pin from phy
  input  wire logic                sync_lost_i,       // receive sync lost, from phy pin
  output logic                     lock_ref_o,        // lock to reference, to phy
  output logic                     comma_enable_o,    // comma detect enable, to phy
  output logic                     pcs_mode_o,        // phy interface type in use
  output logic                     cpu_wide_o,        // cpu bus is 16 bits
  input  wire pmlf_pkg::pmlf_beat_s tx_beat_i,        // transmit data toward line
  output pmlf_pkg::pmlf_beat_s     line_tx_o,         // data sent to the line
  input  wire pmlf_pkg::pmlf_beat_s line_rx_i,        // data received from the line
  input  wire logic [31:0]         rx_status_i,       // status word, valid with last beat
  output pmlf_pkg::pmlf_bus_s      pkt_bus_o          // packet bus access
);
  import pmlf_pkg::*;

  // synchroniser chains for pin inputs
  pmlf_cpu_s   cpu_s1_q, cpu_s2_q, cpu_s3_q;   // s1 read only by s2
  logic        sd_s1_q, sd_s2_q;               // signal detect chain
  logic        sl_s1_q, sl_s2_q;               // sync lost chain

  // pin synchronisers, no logic between stages
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cpu_s1_q <= '0;
      cpu_s2_q <= '0;
      cpu_s3_q <= '0;
      sd_s1_q  <= 1'b0;
      sd_s2_q  <= 1'b0;
      sl_s1_q  <= 1'b0;
      sl_s2_q  <= 1'b0;
    end else begin
      cpu_s1_q <= cpu_req_i;
      cpu_s2_q <= cpu_s1_q;
      cpu_s3_q <= cpu_s2_q;  // previous value for strobe edges
      sd_s1_q  <= line_signal_detect_in_i;
      sd_s2_q  <= sd_s1_q;
      sl_s1_q  <= sync_lost_i;
      sl_s2_q  <= sl_s1_q;
    end
  end

  // mode register and read path state
  logic [15:0] mode_q, mode_d;          // port_working_mode
  logic [15:0] rdata_q, rdata_d;        // registered read data
  logic        rd_oe_q, rd_oe_d;        // read drive enable
  logic        wr_evt, rd_evt;          // one-cycle strobe edges
  logic        hit_lo, hit_hi;          // address decode
  logic        wide;                    // current cpu width

  // strobe edges are taken on the synchronised copies only
  assign wr_evt = cpu_s2_q.cs && cpu_s2_q.wr && !(cpu_s3_q.cs && cpu_s3_q.wr);
  assign rd_evt = cpu_s2_q.cs && cpu_s2_q.rd && !(cpu_s3_q.cs && cpu_s3_q.rd);
  assign hit_lo = (cpu_s2_q.addr == PMLF_ADDR_LO);
  assign hit_hi = (cpu_s2_q.addr == PMLF_ADDR_HI);
  assign wide   = mode_q[PMLF_BIT_WIDTH];

  // register write and read decode
  always_comb begin
    mode_d  = mode_q;
    rdata_d = rdata_q;
    rd_oe_d = cpu_s2_q.cs && cpu_s2_q.rd;  // drive only while read is held
    if (wr_evt) begin
      if (wide && hit_lo) begin
        mode_d = cpu_s2_q.wdata & PMLF_MODE_MASK;
      end else if (!wide && hit_lo) begin
        // narrow bus: only data lines 7:0 carry the byte
        mode_d[7:0] = cpu_s2_q.wdata[7:0] & PMLF_MODE_MASK[7:0];
      end else if (!wide && hit_hi) begin
        mode_d[15:8] = cpu_s2_q.wdata[7:0] & PMLF_MODE_MASK[15:8];
      end
    end
    if (rd_evt) begin
      // unmapped addresses read as zero
      rdata_d = 16'h0000;
      if (hit_lo && wide) begin
        rdata_d = mode_q;
      end else if (hit_lo) begin
        rdata_d = {8'h00, mode_q[7:0]};
      end else if (hit_hi && !wide) begin
        rdata_d = {8'h00, mode_q[15:8]};
      end
    end
  end

  // register stage for the cpu port
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mode_q  <= PMLF_MODE_RESET;
      rdata_q <= 16'h0000;
      rd_oe_q <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      rdata_q <= rdata_d;
      rd_oe_q <= rd_oe_d;
    end
  end

  // a width change takes effect on the access after the write
  assign cpu_rdata_o    = rdata_q;
  assign cpu_rdata_oe_o = rd_oe_q;
  assign cpu_wide_o     = wide;

  // mode fields in use
  logic pcs, sd_eff;
  assign pcs        = mode_q[PMLF_BIT_PCS];
  assign pcs_mode_o = pcs;

  // override only has meaning on the coding sublayer interface
  assign sd_eff = sd_s2_q || (pcs && mode_q[PMLF_BIT_OVR]);

  // phy control outputs; held low with a gmii phy
  logic lock_d, lock_q, comma_d, comma_q;
  always_comb begin
    lock_d  = pcs && mode_q[PMLF_BIT_LOCK] && !sd_eff;
    comma_d = pcs && (mode_q[PMLF_BIT_COMMA] || sl_s2_q);
  end

  // phy control outputs are registered
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      lock_q  <= 1'b0;
      comma_q <= 1'b0;
    end else begin
      lock_q  <= lock_d;
      comma_q <= comma_d;
    end
  end

  assign lock_ref_o     = lock_q;
  assign comma_enable_o = comma_q;

  // byte order swap, used on data beats
  function automatic logic [31:0] pmlf_order(input logic [31:0] d, input logic big);
    pmlf_order = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction : pmlf_order

  // loopback path and receive source select
  pmlf_beat_s  rx_src;                  // beat entering the unloader
  pmlf_beat_s  ltx_q, ltx_d;            // line transmit register
  logic        loop;

  assign loop = mode_q[PMLF_BIT_LOOP];

  // in loopback the line gets nothing and its packets are dropped
  always_comb begin
    rx_src = loop ? tx_beat_i : line_rx_i;
    ltx_d  = loop ? '0 : tx_beat_i;
  end

  // line transmit register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ltx_q <= '0;
    end else begin
      ltx_q <= ltx_d;
    end
  end

  assign line_tx_o = ltx_q;

  // unloader: data beats, then the status access when enabled
  pmlf_bus_s   bus_q, bus_d;
  logic        st_pend_q, st_pend_d;    // status owed next access
  logic [31:0] st_q, st_d;              // captured status word

  // a new beat in the status slot would clash; the rx fifo
  // upstream leaves one idle cycle after each last beat
  always_comb begin
    bus_d     = '0;
    st_pend_d = 1'b0;
    st_d      = st_q;
    if (st_pend_q) begin
      bus_d.valid  = 1'b1;
      bus_d.status = 1'b1;
      bus_d.data   = st_q;  // status word is not byte swapped
    end else if (rx_src.valid) begin
      bus_d.valid = 1'b1;
      bus_d.data  = pmlf_order(rx_src.data, mode_q[PMLF_BIT_ORDER]);
      if (rx_src.last && !mode_q[PMLF_BIT_PS_OFF]) begin
        st_pend_d = 1'b1;
        st_d      = rx_status_i;
      end
    end
  end

  // unloader registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      bus_q     <= '0;
      st_pend_q <= 1'b0;
      st_q      <= 32'h0000_0000;
    end else begin
      bus_q     <= bus_d;
      st_pend_q <= st_pend_d;
      st_q      <= st_d;
    end
  end

  assign pkt_bus_o = bus_q;

endmodule : pmlf_port_mode

// [common/pmlf_pkg.sv]
package pmlf_pkg;

  // cpu port byte addresses of the mode register
  localparam logic [7:0]  PMLF_ADDR_LO     = 8'h24;  // low byte, or whole word in 16-bit mode
  localparam logic [7:0]  PMLF_ADDR_HI     = 8'h25;  // high byte in 8-bit mode

  // field positions inside the mode register
  localparam int          PMLF_BIT_PS_OFF  = 9;      // status_append_disable
  localparam int          PMLF_BIT_ORDER   = 8;      // byte_order_select
  localparam int          PMLF_BIT_LOCK    = 7;      // lock_reference_enable
  localparam int          PMLF_BIT_COMMA   = 6;      // comma_detect_force
  localparam int          PMLF_BIT_LOOP    = 5;      // internal_loopback
  localparam int          PMLF_BIT_WIDTH   = 2;      // cpu_width_select
  localparam int          PMLF_BIT_OVR     = 1;      // detect_override
  localparam int          PMLF_BIT_PCS     = 0;      // coding_sublayer_phy_mode

  // value after reset and mask of implemented bits
  localparam logic [15:0] PMLF_MODE_RESET  = 16'h0000;
  localparam logic [15:0] PMLF_MODE_MASK   = 16'h03e7;

  // synchroniser depth for pin inputs
  localparam int          PMLF_SYNC_STAGES = 2;

  // one beat of packet data on the internal paths
  typedef struct packed {
    logic        valid;  // beat present this cycle
    logic        last;   // final data beat of the packet
    logic [31:0] data;   // packet bytes, byte 0 in bits 7:0
  } pmlf_beat_s;

  // one access on the packet bus
  typedef struct packed {
    logic        valid;   // access present this cycle
    logic        status;  // access carries the receive status word
    logic [31:0] data;    // bus data
  } pmlf_bus_s;

  // cpu port request as seen at the pins
  typedef struct packed {
    logic        cs;     // chip select, high active
    logic        wr;     // write strobe, high active
    logic        rd;     // read strobe, high active
    logic [7:0]  addr;   // byte address
    logic [15:0] wdata;  // write data
  } pmlf_cpu_s;

endpackage : pmlf_pkg

// [tb/pmlf_phy_model.sv]
`timescale 1ns/1ps
// behavioural phy: line status pins and single-beat frames
module pmlf_phy_model (
  input  wire logic          clk_i,       // device clock
  input  wire logic          sd_want_i,   // signal present on line
  input  wire logic          lost_want_i, // receive sync lost
  input  wire logic          send_i,      // emit one frame beat
  input  wire logic [31:0]   data_i,      // frame data
  output logic               sd_o,        // signal detect pin
  output logic               lost_o,      // loss of sync pin
  output pmlf_pkg::pmlf_beat_s beat_o     // received beat toward the port
);
  import pmlf_pkg::*;
  // pins move just after the edge; idle data is inverted so stale bytes never pass for data
  always @(posedge clk_i) begin
    sd_o   <= sd_want_i;
    lost_o <= lost_want_i;
    beat_o <= send_i ? pmlf_beat_s'{1'b1, 1'b1, data_i} : pmlf_beat_s'{1'b0, 1'b0, ~data_i};
  end
endmodule : pmlf_phy_model

// [tb/pmlf_port_mode_chk.sv]
`timescale 1ns/1ps
// watches the mode-driven outputs of one port
module pmlf_port_mode_chk (
  input wire logic                 sys_clk_i,
  input wire logic                 rst_n_i,
  input wire logic [15:0]          cpu_rdata_o,
  input wire logic                 line_signal_detect_in_i,
  input wire logic                 sync_lost_i,
  input wire logic                 lock_ref_o,
  input wire logic                 comma_enable_o,
  input wire logic                 pcs_mode_o,
  input wire logic                 cpu_wide_o,
  input wire pmlf_pkg::pmlf_beat_s tx_beat_i,
  input wire pmlf_pkg::pmlf_beat_s line_tx_o,
  input wire logic [31:0]          rx_status_i,
  input wire pmlf_pkg::pmlf_bus_s  pkt_bus_o
);
  import pmlf_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rst; !$past(rst_n_i) |-> cpu_rdata_o == 16'h0000 && !pcs_mode_o && !cpu_wide_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_sts_after; pkt_bus_o.status |-> $past(pkt_bus_o.valid && !pkt_bus_o.status); endproperty
  a_sts_after: assert property (p_sts_after) else $error("status not after data access");
  property p_sts_word; pkt_bus_o.status |-> pkt_bus_o.data == $past(rx_status_i, 2); endproperty
  a_sts_word: assert property (p_sts_word) else $error("status word wrong");
  property p_sts_valid; pkt_bus_o.status |-> pkt_bus_o.valid; endproperty
  a_sts_valid: assert property (p_sts_valid) else $error("status access without valid");
  property p_tx; line_tx_o.valid |-> $past(tx_beat_i.valid) && line_tx_o.data == $past(tx_beat_i.data); endproperty
  a_tx: assert property (p_tx) else $error("line data not from transmit path");
  property p_gmii; $rose(comma_enable_o) || lock_ref_o |-> $past(pcs_mode_o); endproperty
  a_gmii: assert property (p_gmii) else $error("phy control active in gmii mode");
  property p_comma; $past(pcs_mode_o) && $past(sync_lost_i, 3) |-> comma_enable_o; endproperty
  a_comma: assert property (p_comma) else $error("comma enable missing on sync loss");
  property p_lock; lock_ref_o |-> !$past(line_signal_detect_in_i, 3); endproperty
  a_lock: assert property (p_lock) else $error("lock asserted with signal present");
  c_sts: cover property (pkt_bus_o.status);
  c_lock: cover property (lock_ref_o);
  c_comma: cover property (comma_enable_o);
endmodule : pmlf_port_mode_chk

// [tb/pmlf_port_mode_bench.sv]
`timescale 1ns/1ps
// drives cpu port, packet paths and phy model; judges the outputs
module pmlf_port_mode_bench;
  import pmlf_pkg::*;
  localparam logic [31:0] LXD = 32'h1122_3344; // line frame data
  localparam logic [31:0] TXD = 32'ha1b2_c3d4; // transmit frame data
  localparam logic [31:0] STS = 32'h5a5a_c3c3; // receive status word
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  pmlf_cpu_s   cpu_req_i = '0;
  pmlf_beat_s  tx_beat_i = '0;
  logic [31:0] rx_status_i = STS;
  logic        sd = 1'b0;
  logic        lost = 1'b0;
  logic        send = 1'b0;
  logic [15:0] cpu_rdata_o;
  logic        cpu_rdata_oe_o, line_signal_detect_in_i, sync_lost_i, lock_ref_o, comma_enable_o, pcs_mode_o, cpu_wide_o;
  pmlf_beat_s  line_tx_o, line_rx_i;
  pmlf_bus_s   pkt_bus_o;
  int          n_mismatch = 0;
  int          checks = 0;
  pmlf_port_mode i_pmlf_port_mode (.sys_clk_i, .rst_n_i, .cpu_req_i, .cpu_rdata_o, .cpu_rdata_oe_o,
    .line_signal_detect_in_i, .sync_lost_i, .lock_ref_o, .comma_enable_o, .pcs_mode_o, .cpu_wide_o,
    .tx_beat_i, .line_tx_o, .line_rx_i, .rx_status_i, .pkt_bus_o);
  pmlf_phy_model i_pmlf_phy_model (.clk_i(sys_clk_i), .sd_want_i(sd), .lost_want_i(lost), .send_i(send),
    .data_i(LXD), .sd_o(line_signal_detect_in_i), .lost_o(sync_lost_i), .beat_o(line_rx_i));
  initial forever #20 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  // strobes held past the synchroniser lag, then a gap so the port sees them fall
  task automatic cpu(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    cpu_req_i = '{1'b1, wr, !wr, a, d};
    repeat (6) @(negedge sys_clk_i);
    q = cpu_rdata_o;
    chk(32'(cpu_rdata_oe_o), 32'(!wr));
    cpu_req_i = '0;
    repeat (3) @(negedge sys_clk_i);
  endtask : cpu
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    cpu(1'b0, a, 16'h0000, q);
    chk(32'(q), 32'(e));
  endtask : rd
  // narrow bus: high byte first, since setting the width bit would hide it
  // one port only here: software would repeat the width and pcs writes on its twin
  task automatic set_mode(input logic [15:0] m);
    logic [15:0] q;
    if (cpu_wide_o === 1'b1) cpu(1'b1, PMLF_ADDR_LO, m, q);
    else begin
      cpu(1'b1, PMLF_ADDR_HI, {8'h00, m[15:8]}, q);
      cpu(1'b1, PMLF_ADDR_LO, {8'h00, m[7:0]}, q);
    end
  endtask : set_mode
  // unmapped writes, wide and narrow pairing of both addresses
  task automatic t_regs;
    logic [15:0] q;
    rd(PMLF_ADDR_LO, 16'h0000);
    rd(8'h30, 16'h0000);
    cpu(1'b1, 8'h30, 16'hffff, q);
    rd(PMLF_ADDR_LO, 16'h0000);
    set_mode(16'hffff);
    chk(32'(cpu_wide_o), 32'h1);
    rd(PMLF_ADDR_LO, 16'h03e7);
    rd(PMLF_ADDR_HI, 16'h0000);
    cpu(1'b1, PMLF_ADDR_HI, 16'hffff, q);
    rd(PMLF_ADDR_LO, 16'h03e7);
    set_mode(16'h0000);
    rd(PMLF_ADDR_HI, 16'h0000);
    set_mode(16'h0300);
    rd(PMLF_ADDR_HI, 16'h0003);
    rd(PMLF_ADDR_LO, 16'h0000);
  endtask : t_regs
  // mid-run reset must bring back the all-zero mode
  task automatic t_reset;
    set_mode(16'h0105);
    chk(32'(cpu_wide_o), 32'h1);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    chk(32'({pcs_mode_o, cpu_wide_o, lock_ref_o, comma_enable_o}), 32'h0);
    rd(PMLF_ADDR_LO, 16'h0000);
  endtask : t_reset
  // one single-beat frame; counts data, status and line accesses
  task automatic pkt(input logic [15:0] m, input logic lp);
    logic [31:0] s;
    logic [3:0]  nd = 4'h0;
    logic [3:0]  ns = 4'h0;
    logic [3:0]  nt = 4'h0;
    s = lp ? TXD : LXD;
    rx_status_i = STS;
    set_mode(m);
    send = 1'b1;
    tx_beat_i = '{1'b1, 1'b1, TXD};
    repeat (5) begin
      @(negedge sys_clk_i);
      send = 1'b0;
      tx_beat_i = '0;
      if (line_tx_o.valid === 1'b1) begin
        nt++;
        chk(line_tx_o.data, TXD);
      end
      if (pkt_bus_o.valid === 1'b1 && pkt_bus_o.status === 1'b1) begin
        ns++;
        chk(pkt_bus_o.data, STS);
      end else if (pkt_bus_o.valid === 1'b1) begin
        nd++;
        // status must already be taken with the last beat; a late capture shows the inverse
        rx_status_i = ~STS;
        chk(pkt_bus_o.data, m[8] ? {s[7:0], s[15:8], s[23:16], s[31:24]} : s);
      end
    end
    chk(32'({nd, ns, nt}), 32'({4'h1, 4'(!m[9]), 4'(!lp)}));
  endtask : pkt
  task automatic phy(input logic [15:0] m, input logic s, input logic l, input logic [1:0] e);
    set_mode(m);
    sd = s;
    lost = l;
    repeat (6) @(negedge sys_clk_i);
    chk(32'({lock_ref_o, comma_enable_o, pcs_mode_o}), 32'({e, m[0]}));
  endtask : phy
  initial begin
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    t_regs();
    pkt(16'h0000, 1'b0);
    pkt(16'h0100, 1'b0);
    pkt(16'h0200, 1'b0);
    pkt(16'h0120, 1'b1);
    phy(16'h0081, 1'b0, 1'b0, 2'b10);
    phy(16'h0081, 1'b1, 1'b0, 2'b00);
    phy(16'h0083, 1'b0, 1'b0, 2'b00);
    phy(16'h0041, 1'b1, 1'b0, 2'b01);
    phy(16'h0001, 1'b1, 1'b0, 2'b00);
    phy(16'h0001, 1'b1, 1'b1, 2'b01);
    phy(16'h00c0, 1'b0, 1'b1, 2'b00);
    t_reset();
    test_done();
  end
  // hang guard
  initial begin
    #800000;
    n_mismatch++;
    test_done();
  end
endmodule : pmlf_port_mode_bench
bind pmlf_port_mode pmlf_port_mode_chk i_pmlf_port_mode_chk (.sys_clk_i, .rst_n_i, .cpu_rdata_o,
  .line_signal_detect_in_i, .sync_lost_i, .lock_ref_o, .comma_enable_o, .pcs_mode_o, .cpu_wide_o,
  .tx_beat_i, .line_tx_o, .rx_status_i, .pkt_bus_o);
